// File: shared/gripper_io_defs.svh
// constants for the gripper tool-io command and status logic
// assumes a 20 MHz system clock; times are in msec
`ifndef GRIPPER_IO_DEFS_SVH
`define GRIPPER_IO_DEFS_SVH

`define CLK_HZ                 20000000
`define CMD_HOLD_MS            200
`define CMD_HOLD_CYC           ((`CLK_HZ / 1000) * `CMD_HOLD_MS)
`define RELEASE_OPEN_MS        2000
`define RELEASE_OPEN_CYC       ((`CLK_HZ / 1000) * `RELEASE_OPEN_MS)
`define GRIP_TIMEOUT_MS        2000
`define GRIP_TIMEOUT_CYC       ((`CLK_HZ / 1000) * `GRIP_TIMEOUT_MS)
`define OUT_LAG_MS             99
`define OUT_LAG_CYC            ((`CLK_HZ / 1000) * `OUT_LAG_MS)
// pressures in 0.1 kPa steps, gauge, negative is vacuum
`define RELEASE_OK_DKPA        (-10)
`define MAXVAC_CAUTION_DKPA    (-700)
`define STD_ATM_DKPA           1013
`define CMD_GRIP_BIT           0
`define CMD_RELEASE_BIT        1

`endif

// File: shared/gripper_io_pkg.sv
// types shared by the gripper tool-io logic
// assumes nothing beyond the defs header
package gripper_io_pkg;
	typedef enum logic [1:0] {
		CMD_IDLE    = 2'h0,
		CMD_GRIP    = 2'h1,
		CMD_RELEASE = 2'h2
	} cmd_t;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_GRIP    = 4'h2,
		ST_RELEASE = 4'h4,
		ST_ALARM   = 4'h8
	} state_t;

	typedef enum logic [1:0] {
		RES_NONE = 2'h0,
		RES_OK   = 2'h1,
		RES_FAIL = 2'h2
	} result_t;
endpackage : gripper_io_pkg

// File: shared/cmd_if.sv
// command hand-off between the input filter and the sequencer
// assumes one clock, sys_clk
`timescale 1ns/1ps
`default_nettype none
interface cmd_if;
	import gripper_io_pkg::*;
	cmd_t cmd;
	logic new_cmd;
	modport src (output cmd, output new_cmd);
	modport dst (input cmd, input new_cmd);
endinterface : cmd_if
`default_nettype wire

// File: hw/cmd_filter.sv
// synchronises the two command pins and accepts a level held steady long enough
// assumes pins are asynchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "gripper_io_defs.svh"
module cmd_filter #(
	parameter int HOLD_CYC = `CMD_HOLD_CYC
) (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] cmd_pin,
	cmd_if.src              cmd_o
);
	import gripper_io_pkg::*;

	logic [1:0] meta_q;
	logic [1:0] sync_q;
	logic [1:0] prev_q;
	logic [31:0] hold_q;
	cmd_t        cmd_q;
	logic        new_q;
	cmd_t        decoded;
	logic        stable_done;

	// only one pin active selects a command; both or none means idle
	assign decoded = (sync_q == 2'h1) ? CMD_GRIP :
	                 (sync_q == 2'h2) ? CMD_RELEASE : CMD_IDLE;
	assign stable_done = (hold_q == 32'(HOLD_CYC - 1)) && (sync_q == prev_q);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= 2'h0;
			sync_q <= 2'h0;
		end else begin
			meta_q <= cmd_pin;
			sync_q <= meta_q;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= 2'h0;
			hold_q <= 32'h0;
			cmd_q  <= CMD_IDLE;
			new_q  <= 1'b0;
		end else begin
			prev_q <= sync_q;
			new_q  <= 1'b0;
			if (sync_q != prev_q)
				hold_q <= 32'h0;
			else if (hold_q != 32'(HOLD_CYC - 1))
				hold_q <= hold_q + 32'h1;
			if (stable_done && decoded != cmd_q) begin
				cmd_q <= decoded;
				new_q <= 1'b1;
			end
		end
	end

	assign cmd_o.cmd = cmd_q;
	assign cmd_o.new_cmd = new_q;

	property p_hold;
		@(posedge sys_clk) disable iff (!reset_n)
		new_q |-> $past(hold_q) == 32'(HOLD_CYC - 1) && $past(sync_q) == $past(prev_q);
	endproperty
	a_hold : assert property (p_hold) else $error("command taken before hold time");
endmodule : cmd_filter
`default_nettype wire

// File: hw/gripper_io_ctrl.sv
// command sequencer, valve timing, status encoding and max-vacuum diagnostic
// assumes pressure samples are already in sys_clk domain, signed 0.1 kPa gauge
`timescale 1ns/1ps
`default_nettype none
`include "gripper_io_defs.svh"

// Summary of operation
// - one active input selects grip or release; none or both means idle
// - pass/fail variant: 00 idle, 10 success, 01 failure, 11 alarm
// - grip-check variant: out0 follows gripping, out1 follows alarm
// - grip-check variant: out0 keeps its pre-alarm level when an alarm is raised
// - out1 clears on any new command without alarm_in in the same cycle, or on restart
// - release opens the valve for exactly 2000 msec
// - grip after release success closes the valve immediately
// - release succeeds once pressure is back to -1.0 kPa
// - max-vacuum diagnostic warns when weaker than -70 kPa
// - factory max vacuum stored normalised to 101.3 kPa
// - grip fails if threshold not reached within 2000 msec
// - outputs update a few cycles after a command has held steady for 200 msec
module gripper_io_ctrl #(
	parameter int                RELEASE_CYC = `RELEASE_OPEN_CYC,
	parameter int                GRIP_TO_CYC = `GRIP_TIMEOUT_CYC,
	parameter int                HOLD_CYC    = `CMD_HOLD_CYC,
	parameter logic signed [15:0] FACTORY_MAXVAC = -16'sh02EE
) (
	input  wire logic               sys_clk,
	input  wire logic               reset_n,
	input  wire logic [1:0]         cmd_pin,
	input  wire logic               variant_check,
	input  wire logic signed [15:0] pressure,
	input  wire logic signed [15:0] grip_threshold,
	input  wire logic [15:0]        grip_threshold_hysteresis,
	input  wire logic               alarm_in,
	input  wire logic               diag_start,
	input  wire logic signed [15:0] diag_value,
	output logic                    status_out0,
	output logic                    status_out1,
	output logic                    pump_on,
	output logic                    release_valve,
	output logic                    diag_valid,
	output logic                    diag_caution,
	output logic signed [15:0]      factory_maxvac
);
	import gripper_io_pkg::*;

	// ****************************************
	// command input
	// ****************************************
	cmd_if cmd_bus ();

	cmd_filter #(
		.HOLD_CYC (HOLD_CYC)
	) u_filter (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.cmd_pin (cmd_pin),
		.cmd_o   (cmd_bus)
	);

	// ****************************************
	// pressure judgement
	// ****************************************
	logic signed [16:0] drop_level;
	logic               at_grip;
	logic               below_drop;
	logic               at_release_ok;

	// vacuum is negative, so the drop level lies hysteresis steps towards atmosphere
	assign drop_level    = 17'(grip_threshold) + 17'(signed'({1'b0, grip_threshold_hysteresis}));
	assign at_grip       = pressure <= grip_threshold;
	assign below_drop    = 17'(pressure) > drop_level;
	assign at_release_ok = pressure >= 16'(`RELEASE_OK_DKPA);

	// ****************************************
	// sequencer
	// ****************************************
	state_t      state_q, state_d;
	result_t     res_q, res_d;
	logic        grip_ok_q, grip_ok_d;
	logic        valve_q, valve_d;
	logic [31:0] tmr_q, tmr_d;
	logic        grip_cmd, rel_cmd;
	logic        tmr_grip_done, tmr_rel_done;
	logic        early_grip;

	assign grip_cmd      = cmd_bus.new_cmd && cmd_bus.cmd == CMD_GRIP;
	assign rel_cmd       = cmd_bus.new_cmd && cmd_bus.cmd == CMD_RELEASE;
	assign tmr_grip_done = tmr_q >= 32'(GRIP_TO_CYC - 1);
	assign tmr_rel_done  = tmr_q >= 32'(RELEASE_CYC - 1);
	assign early_grip    = state_q == ST_RELEASE && res_q == RES_OK && grip_cmd;

	always_comb begin
		state_d   = state_q;
		res_d     = res_q;
		grip_ok_d = grip_ok_q;
		valve_d   = valve_q;
		tmr_d     = tmr_q + 32'h1;
		if (cmd_bus.new_cmd) begin
			res_d = RES_NONE;
			tmr_d = 32'h0;
		end
		if (grip_cmd) begin
			state_d   = ST_GRIP;
			grip_ok_d = 1'b0;
			valve_d   = 1'b0;
		end else if (rel_cmd) begin
			state_d   = ST_RELEASE;
			grip_ok_d = 1'b0;
			valve_d   = 1'b1;
		end else if (cmd_bus.new_cmd) begin
			state_d   = ST_IDLE;
			grip_ok_d = 1'b0;
			valve_d   = 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					tmr_d = tmr_q;
				end
				// an alarm in mid-release must not leave the valve coil energised
				ST_ALARM: begin
					if (!valve_q)
						tmr_d = tmr_q;
					else if (tmr_rel_done)
						valve_d = 1'b0;
				end
				ST_GRIP: begin
					if (!grip_ok_q && at_grip) begin
						grip_ok_d = 1'b1;
						res_d     = RES_OK;
					end else if (!grip_ok_q && tmr_grip_done) begin
						res_d = RES_FAIL;
					end else if (grip_ok_q && below_drop) begin
						grip_ok_d = 1'b0;
						res_d     = RES_FAIL;
					end
				end
				ST_RELEASE: begin
					if (res_q == RES_NONE && at_release_ok)
						res_d = RES_OK;
					if (tmr_rel_done) begin
						valve_d = 1'b0;
						if (res_q == RES_NONE && !at_release_ok)
							res_d = RES_FAIL;
						state_d = ST_IDLE;
					end
				end
			endcase
		end
		if (alarm_in && !cmd_bus.new_cmd)
			state_d = ST_ALARM;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q   <= ST_IDLE;
			res_q     <= RES_NONE;
			grip_ok_q <= 1'b0;
			valve_q   <= 1'b0;
			tmr_q     <= 32'h0;
		end else begin
			state_q   <= state_d;
			res_q     <= res_d;
			grip_ok_q <= grip_ok_d;
			valve_q   <= valve_d;
			tmr_q     <= tmr_d;
		end
	end

	// ****************************************
	// status outputs
	// ****************************************
	logic alarm_q;
	logic out0_d, out1_d;
	logic out0_pf, out1_pf;

	// alarm latches until a new command clears it, as out1 must
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			alarm_q <= 1'b0;
		else if (alarm_in)
			alarm_q <= 1'b1;
		else if (cmd_bus.new_cmd)
			alarm_q <= 1'b0;
	end

	assign out0_pf = res_q == RES_OK;
	assign out1_pf = res_q == RES_FAIL;
	// during alarm out1 is on; out0 freezes in grip-check mode, is on in pass/fail mode
	assign out0_d  = alarm_q ? (variant_check ? status_out0 : 1'b1) : (variant_check ? grip_ok_q : out0_pf);
	assign out1_d  = alarm_q | (!variant_check & out1_pf);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_out0   <= 1'b0;
			status_out1   <= 1'b0;
			pump_on       <= 1'b0;
			release_valve <= 1'b0;
		end else begin
			status_out0   <= out0_d;
			status_out1   <= out1_d;
			pump_on       <= state_q == ST_GRIP;
			release_valve <= valve_q;
		end
	end

	// ****************************************
	// maximum vacuum diagnostic
	// ****************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			diag_valid     <= 1'b0;
			diag_caution   <= 1'b0;
			factory_maxvac <= 16'sh0000;
		end else begin
			factory_maxvac <= FACTORY_MAXVAC;
			diag_valid     <= diag_start;
			if (diag_start)
				diag_caution <= diag_value > 16'(`MAXVAC_CAUTION_DKPA);
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence s_rel_open;
		rel_cmd ##1 valve_q;
	endsequence

	property p_valve_open;
		@(posedge sys_clk) disable iff (!reset_n) rel_cmd |-> s_rel_open;
	endproperty
	a_valve_open : assert property (p_valve_open) else $error("valve not opened");

	property p_valve_close;
		@(posedge sys_clk) disable iff (!reset_n)
		(valve_q && tmr_rel_done && !cmd_bus.new_cmd) |=> !valve_q;
	endproperty
	a_valve_close : assert property (p_valve_close) else $error("valve not closed");

	property p_early_grip;
		@(posedge sys_clk) disable iff (!reset_n) early_grip |=> !valve_q && state_q == ST_GRIP;
	endproperty
	a_early_grip : assert property (p_early_grip) else $error("grip did not close valve");

	property p_clear_out1;
		@(posedge sys_clk) disable iff (!reset_n)
		(cmd_bus.new_cmd && !alarm_in) |=> ##1 !status_out1;
	endproperty
	a_clear_out1 : assert property (p_clear_out1) else $error("out1 not cleared");

	property p_hold0;
		@(posedge sys_clk) disable iff (!reset_n) (alarm_q && variant_check) |=> $stable(status_out0);
	endproperty
	a_hold0 : assert property (p_hold0) else $error("out0 moved in alarm");

	property p_pf_code;
		@(posedge sys_clk) disable iff (!reset_n)
		(!variant_check && !alarm_q && res_q == RES_FAIL) |=> status_out1 && !status_out0;
	endproperty
	a_pf_code : assert property (p_pf_code) else $error("failure code wrong");

	property p_check_code;
		@(posedge sys_clk) disable iff (!reset_n)
		(variant_check && !alarm_q) |=> status_out0 == $past(grip_ok_q) && !status_out1;
	endproperty
	a_check_code : assert property (p_check_code) else $error("grip check code wrong");

	property p_grip_to;
		@(posedge sys_clk) disable iff (!reset_n)
		(state_q == ST_GRIP && !grip_ok_q && tmr_grip_done && !at_grip && !cmd_bus.new_cmd)
		|=> res_q == RES_FAIL;
	endproperty
	a_grip_to : assert property (p_grip_to) else $error("grip timeout missed");

	property p_diag;
		@(posedge sys_clk) disable iff (!reset_n)
		diag_start |=> diag_valid && diag_caution == ($past(diag_value) > -16'sd700);
	endproperty
	a_diag : assert property (p_diag) else $error("diagnostic judgement wrong");

	property p_pf_alarm;
		@(posedge sys_clk) disable iff (!reset_n)
		(!variant_check && alarm_q) |=> status_out0 && status_out1;
	endproperty
	a_pf_alarm : assert property (p_pf_alarm) else $error("alarm code wrong");

	property p_hold_band;
		@(posedge sys_clk) disable iff (!reset_n)
		(state_q == ST_GRIP && grip_ok_q && !cmd_bus.new_cmd &&
		 17'(pressure) <= 17'(grip_threshold) + 17'(signed'({1'b0, grip_threshold_hysteresis})))
		|=> grip_ok_q;
	endproperty
	a_hold_band : assert property (p_hold_band) else $error("drop flagged inside hysteresis");

	property p_release_ok;
		@(posedge sys_clk) disable iff (!reset_n)
		(state_q == ST_RELEASE && res_q == RES_NONE && pressure >= -16'sh000A && !cmd_bus.new_cmd)
		|=> res_q == RES_OK;
	endproperty
	a_release_ok : assert property (p_release_ok) else $error("release success missed");

	property p_release_fail;
		@(posedge sys_clk) disable iff (!reset_n)
		(state_q == ST_RELEASE && res_q == RES_NONE && tmr_rel_done && pressure < -16'sh000A &&
		 !cmd_bus.new_cmd && !alarm_in) |=> res_q == RES_FAIL && state_q == ST_IDLE;
	endproperty
	a_release_fail : assert property (p_release_fail) else $error("release failure missed");

	property p_valve_stay;
		@(posedge sys_clk) disable iff (!reset_n)
		(valve_q && !tmr_rel_done && !cmd_bus.new_cmd) |=> valve_q;
	endproperty
	a_valve_stay : assert property (p_valve_stay) else $error("valve closed early");

	property p_idle_close;
		@(posedge sys_clk) disable iff (!reset_n)
		(cmd_bus.new_cmd && cmd_bus.cmd == CMD_IDLE) |=> !valve_q && state_q == ST_IDLE && res_q == RES_NONE;
	endproperty
	a_idle_close : assert property (p_idle_close) else $error("idle command not applied");
endmodule : gripper_io_ctrl
`default_nettype wire

// File: testbench/robot_tool_io.sv
// robot-side tool io model: drives the two command pins from a requested level
// assumes sys_clk domain; watches the gripper's release valve output
`timescale 1ns/1ps
`default_nettype none
module robot_tool_io #(
	parameter int HOLD = 20,
	parameter int GAP  = 100
) (
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic [1:0] want,
	input  wire logic       release_valve,
	output logic [1:0]      cmd_pin
);
	int held_q;
	int gap_q;
	// margin of four covers the gripper's input synchroniser
	wire logic can_move = held_q >= HOLD + 4;
	// coil heating: no reopen until the valve has rested
	wire logic gap_ok   = want != 2'h2 || gap_q >= GAP;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_pin <= 2'h0;
			held_q  <= 0;
			gap_q   <= GAP;
		end else begin
			gap_q <= release_valve ? 0 : (gap_q < 1000 ? gap_q + 1 : gap_q);
			if (want != cmd_pin && can_move && gap_ok) begin
				cmd_pin <= want;
				held_q  <= 0;
			end else if (held_q < 1000) begin
				held_q <= held_q + 1;
			end
		end
	end
endmodule : robot_tool_io
`default_nettype wire

// File: testbench/vacuum_gripper_io_control_tb.sv
// self-checking bench for the gripper tool-io command and status logic
// assumes the robot model drives the pins; pressure, alarm and diagnostic come from here
`timescale 1ns/1ps
`default_nettype none
module vacuum_gripper_io_control_tb;
	import gripper_io_pkg::*;
	localparam int                 REL = 100;
	localparam int                 GTO = 100;
	// arbitrary factory value
	localparam logic signed [15:0] FMV = -16'sh0123;
	logic               sys_clk       = 1'b0;
	logic               reset_n       = 1'b0;
	logic [1:0]         want          = 2'h0;
	logic [1:0]         cmd_pin;
	logic               variant_check = 1'b0;
	logic signed [15:0] pressure      = 16'sh0000;
	logic               alarm_in      = 1'b0;
	logic               diag_start    = 1'b0;
	logic signed [15:0] diag_value    = 16'sh0000;
	logic               status_out0, status_out1, pump_on, release_valve, diag_valid, diag_caution;
	logic signed [15:0] factory_maxvac;
	int                 err_count     = 0;
	int                 compares      = 0;

	always #25 sys_clk = ~sys_clk;

	robot_tool_io #(.HOLD(20), .GAP(REL)) i_robot_tool_io (.sys_clk(sys_clk), .reset_n(reset_n),
		.want(want), .release_valve(release_valve), .cmd_pin(cmd_pin));

	gripper_io_ctrl #(.RELEASE_CYC(REL), .GRIP_TO_CYC(GTO), .HOLD_CYC(20), .FACTORY_MAXVAC(FMV))
	i_gripper_io_ctrl (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_pin(cmd_pin),
		.variant_check(variant_check), .pressure(pressure), .grip_threshold(-16'sh01F4),
		.grip_threshold_hysteresis(16'h0032), .alarm_in(alarm_in), .diag_start(diag_start),
		.diag_value(diag_value), .status_out0(status_out0), .status_out1(status_out1),
		.pump_on(pump_on), .release_valve(release_valve), .diag_valid(diag_valid),
		.diag_caution(diag_caution), .factory_maxvac(factory_maxvac));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk_bit(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %b seen %b", n, e, g);
		end
	endtask : chk_bit

	task automatic chk_word(input string n, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk_word

	task automatic chk_cnt(input string n, input int e, input int g);
		compares++;
		if (g != e) begin
			err_count++;
			$display("BAD %s expected %0d seen %0d", n, e, g);
		end
	endtask : chk_cnt

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask : tick

	task automatic drive(input logic [1:0] w, input logic signed [15:0] p, input logic a);
		@(posedge sys_clk);
		want     <= w;
		pressure <= p;
		alarm_in <= a;
		#1;
	endtask : drive

	// bounded waits: the command path is sync, hold filter and two output stages
	task automatic wait_out(input logic e0, input logic e1, input int lim);
		int n;
		n = 0;
		while ({status_out0, status_out1} !== {e0, e1} && n < lim) begin
			tick();
			n++;
		end
		chk_bit("status_out0", e0, status_out0);
		chk_bit("status_out1", e1, status_out1);
	endtask : wait_out

	task automatic wait_valve(input logic e, input int lim);
		int n;
		n = 0;
		while (release_valve !== e && n < lim) begin
			tick();
			n++;
		end
		chk_bit("release_valve", e, release_valve);
	endtask : wait_valve

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_grip();
		drive(2'h1, -16'sh0258, 1'b0);
		wait_out(1'b1, 1'b0, 60);
		chk_bit("pump_on", 1'b1, pump_on);
		// inside the hysteresis band the grip must still count as held
		drive(2'h1, -16'sh01E0, 1'b0);
		repeat (8) tick();
		wait_out(1'b1, 1'b0, 0);
		drive(2'h1, -16'sh0190, 1'b0);
		wait_out(1'b0, 1'b1, 20);
		$display("t_grip done");
	endtask : t_grip

	task automatic t_release();
		drive(2'h2, -16'sh0190, 1'b0);
		wait_valve(1'b1, 300);
		wait_out(1'b0, 1'b0, 60);
		drive(2'h2, 16'sh0000, 1'b0);
		wait_out(1'b1, 1'b0, 20);
		drive(2'h1, 16'sh0000, 1'b0);
		wait_valve(1'b0, 40);
		chk_bit("pump_on", 1'b1, pump_on);
		wait_out(1'b0, 1'b1, GTO + 40);
		$display("t_release done");
	endtask : t_release

	task automatic t_valve_time();
		int n;
		drive(2'h0, 16'sh0000, 1'b0);
		wait_out(1'b0, 1'b0, 60);
		drive(2'h2, 16'sh0000, 1'b0);
		wait_valve(1'b1, 300);
		n = 0;
		while (release_valve === 1'b1 && n < 300) begin
			tick();
			n++;
		end
		chk_cnt("valve_open_cycles", REL, n);
		chk_bit("status_out0", 1'b1, status_out0);
		$display("t_valve_time done");
	endtask : t_valve_time

	task automatic t_release_fail();
		drive(2'h0, -16'sh0190, 1'b0);
		wait_out(1'b0, 1'b0, 60);
		drive(2'h2, -16'sh0190, 1'b0);
		wait_valve(1'b1, 300);
		wait_valve(1'b0, REL + 10);
		wait_out(1'b0, 1'b1, 10);
		$display("t_release_fail done");
	endtask : t_release_fail

	task automatic t_idle_both();
		drive(2'h3, 16'sh0000, 1'b0);
		wait_out(1'b0, 1'b0, 60);
		chk_bit("pump_on", 1'b0, pump_on);
		drive(2'h3, 16'sh0000, 1'b1);
		wait_out(1'b1, 1'b1, 20);
		drive(2'h3, 16'sh0000, 1'b0);
		$display("t_idle_both done");
	endtask : t_idle_both

	task automatic t_alarm();
		@(posedge sys_clk);
		variant_check <= 1'b1;
		drive(2'h1, -16'sh0258, 1'b0);
		wait_out(1'b1, 1'b0, 60);
		drive(2'h1, -16'sh0258, 1'b1);
		wait_out(1'b1, 1'b1, 20);
		drive(2'h0, -16'sh0258, 1'b0);
		wait_out(1'b0, 1'b0, 60);
		drive(2'h0, 16'sh0000, 1'b1);
		wait_out(1'b0, 1'b1, 20);
		drive(2'h0, 16'sh0000, 1'b0);
		$display("t_alarm done");
	endtask : t_alarm

	task automatic t_diag();
		// last entry: a weak raw reading corrected for a low local atmosphere
		logic signed [15:0] v [5] = '{-16'sh02BD, -16'sh02BC, -16'sh02BB, -16'sh0064,
		                             -16'sh02B2 - (16'sh03F5 - 16'sh03C3)};
		logic               c [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 5; i++) begin
			@(posedge sys_clk);
			diag_start <= 1'b1;
			diag_value <= v[i];
			@(posedge sys_clk);
			diag_start <= 1'b0;
			#1;
			chk_bit("diag_valid", 1'b1, diag_valid);
			chk_bit("diag_caution", c[i], diag_caution);
		end
		chk_word("factory_maxvac", FMV, factory_maxvac);
		$display("t_diag done");
	endtask : t_diag

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	initial begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_grip();
		t_release();
		t_valve_time();
		t_release_fail();
		t_idle_both();
		t_alarm();
		t_diag();
		wrap_up();
	end

	// the whole run needs under 2000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		wrap_up();
	end
endmodule : vacuum_gripper_io_control_tb
`default_nettype wire
